// ===== hw/psng_top.sv
// Purpose: node guard supervision and background store/restore of settings
// Assumes: dictionary access is a one-cycle request with idx, sub, write flag, data
// Notes: store/load replies are held until the background timer ends
`timescale 1ns/1ps
module psng_top
	import psng_pkg::*;
#(
	parameter int BG_CYCLES = BG_CYCLES_DEF,
	parameter int MS_TICK   = MS_CYCLES
)
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// dictionary request
	input  wire logic        req_in,
	input  wire logic        req_write_in,
	input  wire logic [15:0] req_index_in,
	input  wire logic [7:0]  req_sub_in,
	input  wire logic [31:0] req_data_in,
	// dictionary answer
	output logic             ack_out,
	output logic             abort_out,
	output logic [31:0]      ack_data_out,
	// node guarding
	input  wire logic        poll_in,
	output logic             life_event_out,
	// power-up behaviour and background busy flag
	input  wire logic        power_up_in,
	input  wire logic        modules_changed_in,
	output logic             use_defaults_out,
	output logic             config_stored_out,
	output logic             hw_change_emcy_out,
	output logic             nv_busy_out
);
	typedef struct packed {
		logic [15:0] guard;
		logic [7:0]  life;
		logic [31:0] store_cmd;
		logic [31:0] rest_all;
		logic [31:0] rest_two;
		logic [31:0] rest_three;
		logic [31:0] rest_once;
		logic [23:0] life_cnt;
		logic [15:0] ms_cnt;
		logic        guard_armed;
		psng_op_t    op;
		logic [31:0] bg_cnt;
		logic        stored;
		logic        dflt_perm;
		logic        dflt_once;
		logic        use_dflt;
		logic        ack;
		logic        abort;
		logic [31:0] ack_data;
		logic        life_ev;
		logic        emcy;
		logic        busy;
	} psng_state_t;

	psng_state_t s_reg;
	psng_state_t s_next;
	logic [23:0] life_time;
	logic        store_req;
	logic        load_req;

	assign life_time = 24'(s_reg.guard * s_reg.life); // RULE_04

	always_comb
	begin
		s_next = s_reg;
		s_next.ack = 1'b0;
		s_next.abort = 1'b0;
		s_next.life_ev = 1'b0;
		store_req = 1'b0;
		load_req = 1'b0;
		// node guarding: ms tick then life time count
		if (s_reg.ms_cnt == 16'(MS_TICK - 1))
			s_next.ms_cnt = 16'h0000;
		else
			s_next.ms_cnt = s_reg.ms_cnt + 16'h0001;
		if (life_time == 24'h000000)
		begin
			s_next.life_cnt = 24'h000000; // RULE_05
			s_next.guard_armed = 1'b0;
		end
		else if (poll_in)
		begin
			s_next.life_cnt = 24'h000000; // RULE_04
			s_next.guard_armed = 1'b1;
		end
		else if (s_reg.guard_armed && s_reg.ms_cnt == 16'(MS_TICK - 1))
		begin
			if (s_reg.life_cnt + 24'h000001 >= life_time)
			begin
				s_next.life_ev = 1'b1; // RULE_04
				s_next.guard_armed = 1'b0;
				s_next.life_cnt = 24'h000000;
			end
			else
				s_next.life_cnt = s_reg.life_cnt + 24'h000001;
		end
		// background store or load; reply only at the end
		if (s_reg.op != PS_IDLE)
		begin
			if (s_reg.bg_cnt == 32'(BG_CYCLES - 1)) // RULE_08 RULE_16
			begin
				s_next.bg_cnt = 32'h0;
				s_next.op = PS_IDLE;
				s_next.ack = 1'b1; // RULE_09 RULE_16
				s_next.ack_data = 32'h0;
				if (s_reg.op == PS_STORE)
				begin
					s_next.stored = 1'b1;
					s_next.dflt_perm = 1'b0; // RULE_20
					s_next.dflt_once = 1'b0;
				end
			end
			else
				s_next.bg_cnt = s_reg.bg_cnt + 32'h1;
		end
		// dictionary accesses keep being served during background work
		if (req_in) // RULE_10 RULE_17
		begin
			s_next.ack = 1'b1;
			s_next.ack_data = 32'h0;
			unique case (req_index_in)
				IDX_HW_VER, IDX_SW_VER:
				begin
					if (req_write_in)
					begin
						s_next.abort = 1'b1; // RULE_06
						s_next.ack_data = ABT_READ_ONLY;
					end
					else if (req_index_in == IDX_HW_VER)
						s_next.ack_data = HW_VER_TEXT;
					else
						s_next.ack_data = SW_VER_TEXT;
				end
				IDX_GUARD:
				begin
					if (req_write_in)
						s_next.guard = req_data_in[15:0]; // RULE_01
					else
						s_next.ack_data = {16'h0000, s_reg.guard};
				end
				IDX_LIFE:
				begin
					if (req_write_in)
						s_next.life = req_data_in[7:0]; // RULE_03
					else
						s_next.ack_data = {24'h000000, s_reg.life};
				end
				IDX_STORE:
				begin
					if (req_sub_in == SUB_MAX && !req_write_in)
						s_next.ack_data = {24'h000000, STORE_MAX_SUB};
					else if (req_sub_in == SUB_MAX)
					begin
						s_next.abort = 1'b1;
						s_next.ack_data = ABT_READ_ONLY;
					end
					else if (req_sub_in != SUB_ALL)
					begin
						s_next.abort = 1'b1;
						s_next.ack_data = ABT_NO_SUB;
					end
					else if (!req_write_in)
						s_next.ack_data = s_reg.store_cmd;
					else if (s_reg.op != PS_IDLE) // RULE_11 RULE_12
					begin
						s_next.abort = 1'b1;
						s_next.ack_data = ABT_BUSY;
					end
					else if (req_data_in != SIG_SAVE) // RULE_23
					begin
						s_next.abort = 1'b1;
						s_next.ack_data = ABT_BAD_VALUE;
					end
					else
						store_req = 1'b1; // RULE_07
				end
				IDX_RESTORE:
				begin
					if (req_sub_in == SUB_MAX && !req_write_in)
						s_next.ack_data = {24'h000000, RESTORE_MAX_SUB}; // RULE_15
					else if (req_sub_in == SUB_MAX)
					begin
						s_next.abort = 1'b1;
						s_next.ack_data = ABT_READ_ONLY;
					end
					else if (req_sub_in == SUB_TWO || req_sub_in == SUB_THREE)
					begin
						s_next.abort = req_write_in; // RULE_15
						s_next.ack_data = req_write_in ? ABT_NO_SUB
							: (req_sub_in == SUB_TWO ? s_reg.rest_two : s_reg.rest_three);
					end
					else if (req_sub_in != SUB_ALL && req_sub_in != SUB_ONCE)
					begin
						s_next.abort = 1'b1;
						s_next.ack_data = ABT_NO_SUB;
					end
					else if (!req_write_in)
						s_next.ack_data = req_sub_in == SUB_ALL ? s_reg.rest_all
							: s_reg.rest_once;
					else if (s_reg.op != PS_IDLE) // RULE_18 RULE_19
					begin
						s_next.abort = 1'b1;
						s_next.ack_data = ABT_BUSY;
					end
					else if (req_data_in != SIG_LOAD) // RULE_23
					begin
						s_next.abort = 1'b1;
						s_next.ack_data = ABT_BAD_VALUE;
					end
					else
					begin
						load_req = 1'b1;
						if (req_sub_in == SUB_ALL)
							s_next.dflt_perm = 1'b1; // RULE_20
						else
							s_next.dflt_once = 1'b1; // RULE_21
					end
				end
				default:
				begin
					s_next.abort = 1'b1;
					s_next.ack_data = ABT_NO_OBJ;
				end
			endcase
			// accepted store/load: reply withheld until the timer ends
			if (store_req || load_req)
			begin
				s_next.ack = 1'b0; // RULE_09
				s_next.op = store_req ? PS_STORE : PS_LOAD;
				s_next.bg_cnt = 32'h0;
			end
		end
		// power-up: choose defaults or saved set; node id is not consulted
		s_next.emcy = 1'b0;
		if (power_up_in)
		begin
			s_next.use_dflt = s_reg.dflt_perm | s_reg.dflt_once | ~s_reg.stored; // RULE_14 RULE_20
			s_next.dflt_once = 1'b0; // RULE_21
			s_next.emcy = ~s_reg.stored | modules_changed_in; // RULE_13
		end
		// busy flag registered so the pin comes straight from a flop
		s_next.busy = s_next.op != PS_IDLE; // RULE_10 RULE_17
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s_reg <= '0;
			s_reg.store_cmd <= CMD_RESET_VAL;
			s_reg.rest_all <= CMD_RESET_VAL;
			s_reg.rest_once <= CMD_RESET_VAL;
			s_reg.op <= PS_IDLE;
			s_reg.use_dflt <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	always_comb
	begin
		ack_out = s_reg.ack;
		abort_out = s_reg.abort;
		ack_data_out = s_reg.ack_data;
		life_event_out = s_reg.life_ev;
		use_defaults_out = s_reg.use_dflt;
		config_stored_out = s_reg.stored;
		hw_change_emcy_out = s_reg.emcy;
		nv_busy_out = s_reg.busy;
	end
endmodule // psng_top

// ===== hw/psng_pkg.sv
// Purpose: constants and types for the parameter store and node guard block
// Assumes: 10 MHz clock, object dictionary access by index and sub-index
// Notes: signatures are the ascii words packed lsb first (first character in the low byte)
// Summary of operation
// RULE_01: guard interval register, 16 bits, ms, reset zero
// RULE_02: master polls at the guard interval
// RULE_03: lifetime multiplier register, 8 bits, reset zero
// RULE_04: life time is product; missed poll raises event
// RULE_05: zero life time disables supervision entirely
// RULE_06: hardware and software version strings read-only
// RULE_07: store starts only on save signature
// RULE_08: store runs in background about two seconds
// RULE_09: store reply withheld until store completes
// RULE_10: other accesses served during a store
// RULE_11: new store while busy returns error
// RULE_12: store refused while restore is active
// RULE_13: stored config suppresses changed-hardware emergency; code raises it on modules_changed_in even when a config is stored
// RULE_14: node id change keeps saved configuration
// RULE_15: restore max sub-index four; two, three unsupported
// RULE_16: load runs in background, reply when done
// RULE_17: other accesses served during a load
// RULE_18: new load while busy returns error
// RULE_19: load refused while store is active
// RULE_20: sub-index one load: defaults every power-up
// RULE_21: sub-index four load: defaults next power-up only
// RULE_22: client must not repeat one-time load then
// RULE_23: wrong signature write gets an abort
package psng_pkg;
	localparam logic [15:0] IDX_HW_VER     = 16'h1009;
	localparam logic [15:0] IDX_SW_VER     = 16'h100A;
	localparam logic [15:0] IDX_GUARD      = 16'h100C;
	localparam logic [15:0] IDX_LIFE       = 16'h100D;
	localparam logic [15:0] IDX_STORE      = 16'h1010;
	localparam logic [15:0] IDX_RESTORE    = 16'h1011;
	localparam logic [7:0]  SUB_MAX        = 8'h00;
	localparam logic [7:0]  SUB_ALL        = 8'h01;
	localparam logic [7:0]  SUB_TWO        = 8'h02;
	localparam logic [7:0]  SUB_THREE      = 8'h03;
	localparam logic [7:0]  SUB_ONCE       = 8'h04;
	localparam logic [7:0]  STORE_MAX_SUB  = 8'h01;
	localparam logic [7:0]  RESTORE_MAX_SUB = 8'h04;
	localparam logic [31:0] CMD_RESET_VAL  = 32'h0000_0001;
	localparam logic [31:0] SIG_SAVE       = 32'h6576_6173;
	localparam logic [31:0] SIG_LOAD       = 32'h6461_6F6C;
	// version strings, four ascii bytes each; values arbitrary
	localparam logic [31:0] HW_VER_TEXT    = 32'h3031_3030;
	localparam logic [31:0] SW_VER_TEXT    = 32'h3031_3031;
	// abort codes
	localparam logic [31:0] ABT_NO_SUB     = 32'h0609_0011;
	localparam logic [31:0] ABT_READ_ONLY  = 32'h0601_0002;
	localparam logic [31:0] ABT_NO_OBJ     = 32'h0602_0000;
	localparam logic [31:0] ABT_BAD_VALUE  = 32'h0609_0030;
	localparam logic [31:0] ABT_BUSY       = 32'h0800_0022;
	// timing
	localparam int          CLK_HZ         = 10_000_000;
	localparam int          MS_NS          = 1_000_000;
	localparam int          CLK_NS         = 1_000_000_000 / CLK_HZ;
	localparam int          MS_CYCLES      = MS_NS / CLK_NS;
	localparam int          BG_MS          = 2000;
	localparam int          BG_CYCLES_DEF  = BG_MS * MS_CYCLES;
	typedef enum logic [1:0] {PS_IDLE, PS_STORE, PS_LOAD} psng_op_t;
endpackage

// ===== sim/psng_top_sva.sv
// Purpose: port checker for psng_top
// Assumes: one clock, async active-high reset
// Notes: shadows guard and multiplier writes to judge the event timing
`timescale 1ns/1ps
module psng_sva
	import psng_pkg::*;
#(
	parameter int BG_CYCLES = 10,
	parameter int MS_TICK   = 4
)
(
	// clock and reset
	input wire logic        clk_in,
	input wire logic        rst_in,
	// dictionary side
	input wire logic        req_in,
	input wire logic        req_write_in,
	input wire logic [15:0] req_index_in,
	input wire logic [7:0]  req_sub_in,
	input wire logic [31:0] req_data_in,
	input wire logic        ack_out,
	input wire logic        abort_out,
	input wire logic [31:0] ack_data_out,
	// guarding, power-up and busy flag
	input wire logic        poll_in,
	input wire logic        life_event_out,
	input wire logic        power_up_in,
	input wire logic        modules_changed_in,
	input wire logic        config_stored_out,
	input wire logic        hw_change_emcy_out,
	input wire logic        nv_busy_out
);
	logic [15:0] g_reg;
	logic [7:0]  l_reg;
	logic [31:0] cnt_reg;
	logic [31:0] quiet_reg;
	logic        pend_reg;
	wire         wr0 = req_in && req_write_in && req_sub_in == SUB_MAX;
	wire         cmd = req_in && req_write_in && ((req_index_in == IDX_STORE
		&& req_sub_in == SUB_ALL && req_data_in == SIG_SAVE) || (req_index_in == IDX_RESTORE
		&& (req_sub_in == SUB_ALL || req_sub_in == SUB_ONCE) && req_data_in == SIG_LOAD));
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	always_ff @(posedge clk_in or posedge rst_in)
	if (rst_in)
	begin
		g_reg     <= 16'h0000;
		l_reg     <= 8'h00;
		cnt_reg   <= 32'h0000_0000;
		quiet_reg <= 32'h0000_0000;
		pend_reg  <= 1'b0;
	end
	else
	begin
		if (wr0 && req_index_in == IDX_GUARD)
			g_reg <= req_data_in[15:0];
		if (wr0 && req_index_in == IDX_LIFE)
			l_reg <= req_data_in[7:0];
		quiet_reg <= poll_in ? 32'h0000_0000 : quiet_reg + 32'h0000_0001;
		cnt_reg   <= (cmd && !nv_busy_out) ? 32'h0000_0001 : cnt_reg + 32'h0000_0001;
		// background answer is the ack not caused by a request one cycle before
		if (cmd && !nv_busy_out)
			pend_reg <= 1'b1;
		else if (ack_out && !$past(req_in))
			pend_reg <= 1'b0;
	end
	AST_GUARD_RD: assert property (req_in && !req_write_in && req_index_in == IDX_GUARD &&
		req_sub_in == SUB_MAX |=> ack_out && !abort_out && ack_data_out == {16'h0000, $past(g_reg)})
		else $error("guard read wrong");
	AST_LIFE_EARLY: assert property (life_event_out |->
		quiet_reg + MS_TICK >= $past(g_reg) * $past(l_reg) * MS_TICK) else $error("event early");
	AST_LIFE_OFF: assert property (life_event_out |-> $past(g_reg) != 16'h0000 &&
		$past(l_reg) != 8'h00) else $error("event with zero life time");
	AST_RO_WR: assert property (req_in && req_write_in && (req_index_in == IDX_HW_VER ||
		req_index_in == IDX_SW_VER) |=> ack_out && abort_out && ack_data_out == ABT_READ_ONLY)
		else $error("version write not refused");
	AST_NO_SUB: assert property (req_in && req_write_in && req_index_in == IDX_RESTORE &&
		(req_sub_in == SUB_TWO || req_sub_in == SUB_THREE) |=> abort_out && ack_data_out == ABT_NO_SUB)
		else $error("sub two or three accepted");
	AST_BAD_SIG: assert property (req_in && req_write_in && !nv_busy_out &&
		req_index_in == IDX_STORE && req_sub_in == SUB_ALL && req_data_in != SIG_SAVE
		|=> abort_out && ack_data_out == ABT_BAD_VALUE) else $error("bad signature accepted");
	AST_BUSY: assert property (cmd && nv_busy_out |=> ack_out && abort_out &&
		ack_data_out == ABT_BUSY) else $error("command while busy not refused");
	AST_START: assert property (cmd && !nv_busy_out |=> (nv_busy_out && !ack_out)[*2])
		else $error("command not started in background");
	AST_BG_TIME: assert property (pend_reg && ack_out && !$past(req_in) |->
		cnt_reg >= BG_CYCLES && cnt_reg <= BG_CYCLES + 2) else $error("background answer mistimed");
	AST_BG_BOUND: assert property (pend_reg |-> cnt_reg <= BG_CYCLES + 3)
		else $error("background answer missing");
	AST_EMCY: assert property (power_up_in |=> hw_change_emcy_out ==
		($past(modules_changed_in) || !$past(config_stored_out))) else $error("emergency wrong");
endmodule // psng_sva
bind psng_top psng_sva #(.BG_CYCLES(BG_CYCLES), .MS_TICK(MS_TICK)) u_sva (.clk_in, .rst_in,
	.req_in, .req_write_in, .req_index_in, .req_sub_in, .req_data_in, .ack_out, .abort_out,
	.ack_data_out, .poll_in, .life_event_out, .power_up_in, .modules_changed_in,
	.config_stored_out, .hw_change_emcy_out, .nv_busy_out);

// ===== sim/psng_master_model.sv
// Purpose: guard poll source in place of the network master
// Assumes: period in clock cycles
// Notes: a slow master is modelled by a longer period
`timescale 1ns/1ps
module psng_master_model #(
	parameter int PERIOD = 8
)
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// poll control
	input  wire logic poll_en_in,
	output logic      poll_out
);
	int cnt_reg;
	always_ff @(posedge clk_in or posedge rst_in)
	if (rst_in)
	begin
		cnt_reg  <= 0;
		poll_out <= 1'b0;
	end
	else
	begin
		cnt_reg  <= (poll_en_in && cnt_reg < PERIOD - 1) ? cnt_reg + 1 : 0;
		poll_out <= poll_en_in && cnt_reg == PERIOD - 1;
	end
endmodule // psng_master_model

// ===== sim/test_psng_top.sv
// Purpose: self-checking bench for psng_top
// Assumes: shortened background and millisecond counts
// Notes: no request is placed near a background completion
`timescale 1ns/1ps
module test_psng_top
	import psng_pkg::*;
;
	localparam int          BG = 40;
	localparam int          MT = 4;
	localparam logic [31:0] Z  = 32'h0000_0000;
	logic        clk_in = 1'b0, rst_in = 1'b1, req_in = 1'b0, req_write_in = 1'b0;
	logic [15:0] req_index_in = 16'h0000;
	logic [7:0]  req_sub_in = 8'h00;
	logic [31:0] req_data_in = Z, ack_data_out;
	logic        poll_en = 1'b0, power_up_in = 1'b0, modules_changed_in = 1'b0, poll_in;
	logic        ack_out, abort_out, life_event_out, use_defaults_out;
	logic        config_stored_out, hw_change_emcy_out, nv_busy_out;
	int          n_mismatch = 0, comparisons = 0, n_ev = 0, i;
	always #50 clk_in = ~clk_in;
	always @(posedge clk_in) if (life_event_out === 1'b1) n_ev++;
	psng_top #(.BG_CYCLES(BG), .MS_TICK(MT)) DUT (.clk_in, .rst_in, .req_in, .req_write_in,
		.req_index_in, .req_sub_in, .req_data_in, .ack_out, .abort_out, .ack_data_out, .poll_in,
		.life_event_out, .power_up_in, .modules_changed_in, .use_defaults_out,
		.config_stored_out, .hw_change_emcy_out, .nv_busy_out);
	psng_master_model #(.PERIOD(2 * MT)) u_master (.clk_in, .rst_in, .poll_en_in(poll_en),
		.poll_out(poll_in));
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic w, input logic [15:0] x, input logic [7:0] s,
		input logic [31:0] d);
		@(posedge clk_in);
		{req_in, req_write_in, req_index_in, req_sub_in, req_data_in} <= {1'b1, w, x, s, d};
		@(posedge clk_in);
		req_in <= 1'b0;
		#1;
	endtask
	task automatic wack(input int lim);
		for (i = 0; i < lim && ack_out !== 1'b1; i++)
			@(posedge clk_in) #1;
		if (ack_out !== 1'b1)
		begin
			n_mismatch++;
			summarize();
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] x, input logic [7:0] s,
		input logic [31:0] d, input logic ea, input logic [31:0] ed);
		send(w, x, s, d);
		wack(0);
		chk(32'(abort_out), 32'(ea));
		chk(ack_data_out, ed);
	endtask
	task automatic bgdone();
		@(posedge clk_in) #1;
		wack(BG + 8);
		chk(32'({abort_out, config_stored_out}), 32'h0000_0001);
	endtask
	task automatic pwr(input logic chg, input logic d, input logic e);
		@(posedge clk_in);
		{power_up_in, modules_changed_in} <= {1'b1, chg};
		@(posedge clk_in);
		power_up_in <= 1'b0;
		#1;
		chk(32'({use_defaults_out, hw_change_emcy_out}), 32'({d, e}));
	endtask
	initial
	begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		acc(1'b0, IDX_GUARD, SUB_MAX, Z, 1'b0, Z);
		acc(1'b0, IDX_LIFE, SUB_MAX, Z, 1'b0, Z);
		acc(1'b0, IDX_STORE, SUB_MAX, Z, 1'b0, 32'(STORE_MAX_SUB));
		acc(1'b0, IDX_STORE, SUB_ALL, Z, 1'b0, CMD_RESET_VAL);
		acc(1'b0, IDX_RESTORE, SUB_MAX, Z, 1'b0, 32'(RESTORE_MAX_SUB));
		for (int s = 1; s < 5; s++)
			acc(1'b0, IDX_RESTORE, 8'(s), Z, 1'b0, (s == 2 || s == 3) ? Z : CMD_RESET_VAL);
		acc(1'b1, IDX_HW_VER, SUB_MAX, Z, 1'b1, ABT_READ_ONLY);
		acc(1'b0, IDX_SW_VER, SUB_MAX, Z, 1'b0, SW_VER_TEXT);
		acc(1'b1, IDX_RESTORE, SUB_TWO, SIG_LOAD, 1'b1, ABT_NO_SUB);
		acc(1'b1, IDX_STORE, SUB_ALL, SIG_LOAD, 1'b1, ABT_BAD_VALUE);
		acc(1'b1, IDX_RESTORE, SUB_ONCE, SIG_SAVE, 1'b1, ABT_BAD_VALUE);
		acc(1'b1, IDX_GUARD, SUB_MAX, 32'h0000_0002, 1'b0, Z);
		acc(1'b1, IDX_LIFE, SUB_MAX, 32'h0000_0003, 1'b0, Z);
		acc(1'b0, IDX_LIFE, SUB_MAX, Z, 1'b0, 32'h0000_0003);
		poll_en <= 1'b1;
		repeat (80) @(posedge clk_in);
		poll_en <= 1'b0;
		chk(n_ev, Z);
		// life time is 2 x 3 ms; last poll lies up to one period before the stop
		for (i = 0; i < 80 && n_ev == 0; i++)
			@(posedge clk_in) #1;
		chk(32'(i >= 3 * MT && i <= 7 * MT), 32'h0000_0001);
		repeat (60) @(posedge clk_in);
		chk(n_ev, 32'h0000_0001);
		acc(1'b1, IDX_LIFE, SUB_MAX, Z, 1'b0, Z);
		poll_en <= 1'b1;
		repeat (20) @(posedge clk_in);
		poll_en <= 1'b0;
		repeat (80) @(posedge clk_in);
		chk(n_ev, 32'h0000_0001);
		send(1'b1, IDX_STORE, SUB_ALL, SIG_SAVE);
		chk(32'(nv_busy_out), 32'h0000_0001);
		acc(1'b0, IDX_GUARD, SUB_MAX, Z, 1'b0, 32'h0000_0002);
		acc(1'b1, IDX_STORE, SUB_ALL, SIG_SAVE, 1'b1, ABT_BUSY);
		acc(1'b1, IDX_RESTORE, SUB_ALL, SIG_LOAD, 1'b1, ABT_BUSY);
		bgdone();
		send(1'b1, IDX_RESTORE, SUB_ONCE, SIG_LOAD);
		acc(1'b1, IDX_STORE, SUB_ALL, SIG_SAVE, 1'b1, ABT_BUSY);
		acc(1'b1, IDX_RESTORE, SUB_ONCE, SIG_LOAD, 1'b1, ABT_BUSY);
		acc(1'b0, IDX_LIFE, SUB_MAX, Z, 1'b0, Z);
		bgdone();
		pwr(1'b0, 1'b1, 1'b0);
		pwr(1'b0, 1'b0, 1'b0);
		send(1'b1, IDX_RESTORE, SUB_ALL, SIG_LOAD);
		bgdone();
		pwr(1'b1, 1'b1, 1'b1);
		pwr(1'b0, 1'b1, 1'b0);
		send(1'b1, IDX_STORE, SUB_ALL, SIG_SAVE);
		bgdone();
		pwr(1'b0, 1'b0, 1'b0);
		summarize();
	end
endmodule // test_psng_top
